/* File: inc/mbcs_map.svh */
// constants for the memory bank chunk select block
// Summary of operation
// - Bit 4 of every value written to I/O port FEH drives the speaker output, so toggling it makes a square wave.
// - A write to port F5H goes to the sound_generator as a register address, and a write to port F6H as its data.
// - On a write to dock_chunk_select, each bit at 1 maps its chunk to the cartridge bank (extension bank when extMode) and each bit at 0 to the main bank.
// - The cartridge and extension ROM banks share the one select register at F4H, so only one of them is mapped.
// - A new mapping applies from the very next memory access after the port write.
// - Writing port FFH with bit 6 set stops the periodic interrupt request; with it clear the request runs normally.
// - Video fetches always read main-bank chunk 2 (primary display) or chunk 3 (second display), whatever the mapping.
`ifndef MBCS_MAP_SVH
`define MBCS_MAP_SVH

`define MBCS_PORT_CHUNK_SEL  8'hF4
`define MBCS_PORT_SND_ADDR   8'hF5
`define MBCS_PORT_SND_DATA   8'hF6
`define MBCS_PORT_SPEAKER    8'hFE
`define MBCS_PORT_CONTROL    8'hFF

`define MBCS_SPEAKER_BIT     4
`define MBCS_INT_OFF_BIT     6
`define MBCS_CHUNK_MSB       15
`define MBCS_CHUNK_LSB       13

`define MBCS_CHUNK_SEL_RST   8'h00
`define MBCS_DISPLAY_PRIMARY 3'h2
`define MBCS_DISPLAY_SECOND  3'h3
`define MBCS_VIDEO_RST       16'h4000

`endif

/* File: inc/mbcs_pkg.sv */
// types for the memory bank chunk select block
package mbcs_pkg;

  typedef enum logic [1:0] {
    MBCS_BANK_HOME = 2'b00,
    MBCS_BANK_DOCK = 2'b01,
    MBCS_BANK_EXT  = 2'b10
  } mbcs_bank_t;

  typedef logic [2:0] mbcs_chunk_t;
  typedef logic [7:0] mbcs_sel_t;

endpackage

/* File: inc/mbcs_map_if.sv */
// carrier between the top and the chunk decoder
`timescale 1ns/1ps
interface mbcs_map_if;
  import mbcs_pkg::*;
  mbcs_sel_t   chunkSel;
  logic        extMode;
  mbcs_chunk_t cpuChunk;
  mbcs_bank_t  cpuBank;

  modport ctrl (output chunkSel, output extMode, output cpuChunk, input cpuBank);
  modport dec  (input chunkSel, input extMode, input cpuChunk, output cpuBank);
endinterface

/* File: core/mbcs_chunk_map.sv */
// chunk decoder: picks the bank for the current processor address
`timescale 1ns/1ps
`include "mbcs_map.svh"
module mbcs_chunk_map
  import mbcs_pkg::*;
(
  // decode link
  mbcs_map_if.dec mapIf
);

  always_comb begin
    if (mapIf.chunkSel[mapIf.cpuChunk] == 1'b0) begin
      mapIf.cpuBank = MBCS_BANK_HOME;
    end else if (mapIf.extMode) begin
      mapIf.cpuBank = MBCS_BANK_EXT;
    end else begin
      mapIf.cpuBank = MBCS_BANK_DOCK;
    end
  end

endmodule

/* File: core/mbcs_top.sv */
// port decode, chunk mapping, sound, speaker and interrupt gating
`timescale 1ns/1ps
`include "mbcs_map.svh"
module mbcs_top
  import mbcs_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // processor I/O cycle
  input  wire logic [7:0]  ioAddr,
  input  wire logic        ioWrite,
  input  wire logic        ioRead,
  input  wire logic [7:0]  ioWrData,
  output logic      [7:0]  ioRdData,
  output logic             ioRdValid,
  // processor memory cycle
  input  wire logic [15:0] memAddr,
  input  wire logic        extMode,
  output logic             homeSelect,
  output logic             dockSelect,
  output logic             extSelect,
  // video fetch
  input  wire logic        videoSecond,
  input  wire logic [12:0] videoOffset,
  output logic      [15:0] videoAddr,
  output logic             videoHome,
  // speaker
  output logic             speaker,
  // sound generator
  output logic      [7:0]  soundAddr,
  output logic             soundAddrStrobe,
  output logic      [7:0]  soundData,
  output logic             soundDataStrobe,
  // interrupt
  input  wire logic        frameTick,
  output logic             intRequest,
  output logic             intDisabled
);

  mbcs_map_if mapIf ();

  mbcs_chunk_map uDec (
    .mapIf (mapIf.dec)
  );

  // port hit decode on the low address byte
  logic hitSel;
  logic hitSndAddr;
  logic hitSndData;
  logic hitSpeaker;
  logic hitControl;

  always_comb begin
    hitSel     = (ioAddr == `MBCS_PORT_CHUNK_SEL);
    hitSndAddr = (ioAddr == `MBCS_PORT_SND_ADDR);
    hitSndData = (ioAddr == `MBCS_PORT_SND_DATA);
    hitSpeaker = (ioAddr == `MBCS_PORT_SPEAKER);
    hitControl = (ioAddr == `MBCS_PORT_CONTROL);
  end

  // chunk select register
  mbcs_sel_t dockChunkSelect;
  mbcs_sel_t next_dockChunkSelect;

  always_comb begin
    next_dockChunkSelect = dockChunkSelect;
    if (ioWrite && hitSel) begin
      next_dockChunkSelect = ioWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      dockChunkSelect <= `MBCS_CHUNK_SEL_RST;
    end else begin
      dockChunkSelect <= next_dockChunkSelect;
    end
  end

  // processor bank decode, live from the register
  always_comb begin
    mapIf.chunkSel = dockChunkSelect;
    mapIf.extMode  = extMode;
    mapIf.cpuChunk = memAddr[`MBCS_CHUNK_MSB:`MBCS_CHUNK_LSB];
    homeSelect     = (mapIf.cpuBank == MBCS_BANK_HOME);
    dockSelect     = (mapIf.cpuBank == MBCS_BANK_DOCK);
    extSelect      = (mapIf.cpuBank == MBCS_BANK_EXT);
  end

  // video address, always main bank
  logic [15:0] next_videoAddr;

  always_comb begin
    if (videoSecond) begin
      next_videoAddr = {`MBCS_DISPLAY_SECOND, videoOffset};
    end else begin
      next_videoAddr = {`MBCS_DISPLAY_PRIMARY, videoOffset};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      videoAddr <= `MBCS_VIDEO_RST;
    end else begin
      videoAddr <= next_videoAddr;
    end
  end

  always_comb begin
    videoHome = 1'b1;
  end

  // speaker
  logic next_speaker;

  always_comb begin
    next_speaker = speaker;
    if (ioWrite && hitSpeaker) begin
      next_speaker = ioWrData[`MBCS_SPEAKER_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      speaker <= 1'b0;
    end else begin
      speaker <= next_speaker;
    end
  end

  // sound generator address and data
  logic [7:0] next_soundAddr;
  logic       next_soundAddrStrobe;
  logic [7:0] next_soundData;
  logic       next_soundDataStrobe;

  always_comb begin
    next_soundAddr       = soundAddr;
    next_soundData       = soundData;
    next_soundAddrStrobe = ioWrite && hitSndAddr;
    next_soundDataStrobe = ioWrite && hitSndData;
    if (next_soundAddrStrobe) begin
      next_soundAddr = ioWrData;
    end
    if (next_soundDataStrobe) begin
      next_soundData = ioWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      soundAddr       <= 8'h00;
      soundAddrStrobe <= 1'b0;
      soundData       <= 8'h00;
      soundDataStrobe <= 1'b0;
    end else begin
      soundAddr       <= next_soundAddr;
      soundAddrStrobe <= next_soundAddrStrobe;
      soundData       <= next_soundData;
      soundDataStrobe <= next_soundDataStrobe;
    end
  end

  // interrupt gating
  logic next_intDisabled;
  logic next_intRequest;

  always_comb begin
    next_intDisabled = intDisabled;
    if (ioWrite && hitControl) begin
      next_intDisabled = ioWrData[`MBCS_INT_OFF_BIT];
    end
    next_intRequest = frameTick && !intDisabled;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      intDisabled <= 1'b0;
      intRequest  <= 1'b0;
    end else begin
      intDisabled <= next_intDisabled;
      intRequest  <= next_intRequest;
    end
  end

  // read back of the select register
  logic [7:0] next_ioRdData;
  logic       next_ioRdValid;

  always_comb begin
    next_ioRdValid = ioRead && hitSel;
    next_ioRdData  = 8'h00;
    if (next_ioRdValid) begin
      next_ioRdData = dockChunkSelect;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ioRdData  <= 8'h00;
      ioRdValid <= 1'b0;
    end else begin
      ioRdData  <= next_ioRdData;
      ioRdValid <= next_ioRdValid;
    end
  end

endmodule

/* File: verif/mbcs_top_monitor.sv */
// assertion checker for the chunk select block
`timescale 1ns/1ps
module mbcs_top_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // processor I/O cycle
  input wire logic [7:0]  ioAddr,
  input wire logic        ioWrite,
  input wire logic        ioRead,
  input wire logic [7:0]  ioWrData,
  input wire logic [7:0]  ioRdData,
  input wire logic        ioRdValid,
  // processor memory cycle
  input wire logic [15:0] memAddr,
  input wire logic        extMode,
  input wire logic        homeSelect,
  input wire logic        dockSelect,
  input wire logic        extSelect,
  // video fetch
  input wire logic        videoSecond,
  input wire logic [12:0] videoOffset,
  input wire logic [15:0] videoAddr,
  input wire logic        videoHome,
  // speaker and sound generator
  input wire logic        speaker,
  input wire logic [7:0]  soundAddr,
  input wire logic        soundAddrStrobe,
  input wire logic [7:0]  soundData,
  input wire logic        soundDataStrobe,
  // interrupt
  input wire logic        frameTick,
  input wire logic        intRequest,
  input wire logic        intDisabled
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_spk; ioWrite && ioAddr == 8'hFE |=> speaker == $past(ioWrData[4]); endproperty
  a_spk: assert property (p_spk) else $error("speaker level wrong");
  property p_sadr; 1 |=> soundAddrStrobe == $past(ioWrite && ioAddr == 8'hF5); endproperty
  a_sadr: assert property (p_sadr) else $error("address strobe wrong");
  property p_sdat; ioWrite && ioAddr == 8'hF6 |=> soundDataStrobe && soundData == $past(ioWrData); endproperty
  a_sdat: assert property (p_sdat) else $error("data strobe wrong");
  property p_rd; 1 |=> ioRdValid == $past(ioRead && ioAddr == 8'hF4); endproperty
  a_rd: assert property (p_rd) else $error("read valid wrong");
  property p_hot; $onehot({homeSelect, dockSelect, extSelect}) && !(dockSelect && extMode); endproperty
  a_hot: assert property (p_hot) else $error("bank select not exclusive");
  property p_off; ioWrite && ioAddr == 8'hFF |=> intDisabled == $past(ioWrData[6]); endproperty
  a_off: assert property (p_off) else $error("interrupt gate wrong");
  property p_int; frameTick && !intDisabled |=> intRequest; endproperty
  a_int: assert property (p_int) else $error("interrupt missing");
  property p_noint; !frameTick |=> !intRequest; endproperty
  a_noint: assert property (p_noint) else $error("spurious interrupt");
  property p_vid; 1 |=> videoHome && videoAddr == {$past(videoSecond) ? 3'h3 : 3'h2, $past(videoOffset)}; endproperty
  a_vid: assert property (p_vid) else $error("video address wrong");
endmodule

/* File: verif/mbcs_cpu_model.sv */
// processor-side model issuing single I/O write and read cycles
`timescale 1ns/1ps
module mbcs_cpu_model (
  input  wire logic clk,
  output logic [7:0] ioAddr,
  output logic [7:0] ioWrData,
  output logic       ioWrite,
  output logic       ioRead
);
  initial {ioAddr, ioWrData, ioWrite, ioRead} = 0;
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    {ioAddr, ioWrData, ioWrite} = {a, d, 1'b1};
    @(negedge clk);
    {ioWrite, ioWrData} = {1'b0, ~d};
  endtask
  task automatic rd(logic [7:0] a);
    @(negedge clk);
    {ioAddr, ioRead} = {a, 1'b1};
    @(negedge clk);
    ioRead = 0;
  endtask
endmodule

/* File: verif/test_mbcs_top.sv */
// self-checking bench for the chunk select block
`timescale 1ns/1ps
module test_mbcs_top;
  logic clk, rstn, extMode, videoSecond, frameTick, ioRdValid, homeSelect, dockSelect, extSelect, videoHome;
  logic speaker, soundAddrStrobe, soundDataStrobe, intRequest, intDisabled, ioWrite, ioRead;
  logic [7:0] ioAddr, ioWrData, ioRdData, soundAddr, soundData;
  logic [15:0] memAddr, videoAddr;
  logic [12:0] videoOffset;
  int n_errors, comparisons, sel, spk, off;
  logic [7:0] ports [6] = '{8'hF4, 8'hF5, 8'hF6, 8'hFE, 8'hFF, 8'hF3};
  mbcs_top dut (
    .clk             (clk),
    .rstn            (rstn),
    .ioAddr          (ioAddr),
    .ioWrite         (ioWrite),
    .ioRead          (ioRead),
    .ioWrData        (ioWrData),
    .ioRdData        (ioRdData),
    .ioRdValid       (ioRdValid),
    .memAddr         (memAddr),
    .extMode         (extMode),
    .homeSelect      (homeSelect),
    .dockSelect      (dockSelect),
    .extSelect       (extSelect),
    .videoSecond     (videoSecond),
    .videoOffset     (videoOffset),
    .videoAddr       (videoAddr),
    .videoHome       (videoHome),
    .speaker         (speaker),
    .soundAddr       (soundAddr),
    .soundAddrStrobe (soundAddrStrobe),
    .soundData       (soundData),
    .soundDataStrobe (soundDataStrobe),
    .frameTick       (frameTick),
    .intRequest      (intRequest),
    .intDisabled     (intDisabled)
  );
  mbcs_cpu_model cpu (
    .clk      (clk),
    .ioAddr   (ioAddr),
    .ioWrData (ioWrData),
    .ioWrite  (ioWrite),
    .ioRead   (ioRead)
  );
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    #200000;
    n_errors++;
    summarize;
  end
  initial begin
    {rstn, extMode, videoSecond, frameTick, memAddr, videoOffset} = 0;
    void'($urandom(32'h91AD));
    repeat (6) @(negedge clk);
    rstn = 1;
    chk(homeSelect, 1);
    for (int i = 0; i < 60; i++) begin
      automatic logic [7:0] a = ports[$urandom % 6];
      automatic logic [7:0] d = 8'($urandom);
      cpu.wr(a, d);
      if (a == 8'hF4) sel = d;
      if (a == 8'hFE) spk = d[4];
      if (a == 8'hFF) off = d[6];
      chk(speaker, spk);
      chk(intDisabled, off);
      chk({soundAddrStrobe, soundDataStrobe}, {a == 8'hF5, a == 8'hF6});
      if (a == 8'hF5 || a == 8'hF6) chk(a[0] ? soundAddr : soundData, d);
      for (int c = 0; c < 8; c++) begin
        if (c > 0) @(negedge clk);
        memAddr = {c[2:0], 13'($urandom)};
        extMode = 1'($urandom);
        #1;
        chk({homeSelect, dockSelect, extSelect}, {!sel[c], sel[c] & !extMode, sel[c] & extMode});
      end
      cpu.rd(a);
      chk({ioRdValid, ioRdData}, a == 8'hF4 ? {1'b1, sel[7:0]} : 9'h0);
      frameTick = 1;
      videoSecond = 1'($urandom);
      videoOffset = 13'($urandom);
      @(negedge clk);
      frameTick = 0;
      chk(intRequest, !off);
      chk(videoAddr, {videoSecond ? 3'h3 : 3'h2, videoOffset});
      chk(videoHome, 1);
    end
    summarize;
  end
endmodule
bind mbcs_top mbcs_top_monitor u_mon (
  .clk (clk), .rstn (rstn), .ioAddr (ioAddr), .ioWrite (ioWrite), .ioRead (ioRead), .ioWrData (ioWrData),
  .ioRdData (ioRdData), .ioRdValid (ioRdValid), .memAddr (memAddr), .extMode (extMode),
  .homeSelect (homeSelect), .dockSelect (dockSelect), .extSelect (extSelect), .videoSecond (videoSecond),
  .videoOffset (videoOffset), .videoAddr (videoAddr), .videoHome (videoHome), .speaker (speaker),
  .soundAddr (soundAddr), .soundAddrStrobe (soundAddrStrobe), .soundData (soundData),
  .soundDataStrobe (soundDataStrobe), .frameTick (frameTick), .intRequest (intRequest),
  .intDisabled (intDisabled)
);
